/* File: rtl/rsmc_capture.sv */
/*
 * Strap capture at hard reset release, I/O mode decode, precharge of the
 * shared busy and retry lines, quiesce request/acknowledge status.
 * Assumes one 50 MHz clock, a synchronous active-high reset_in, strap and
 * line pins asynchronous to the clock, and a plain register port master.
 */
// The plain strobed port and the register offsets were left to the implementer.
// Notes on behaviour
// - At hard reset release, bus width strap high selects 64-bit, low 32-bit.
// - At hard reset release, retry select 1 enables data retry, 0 disables.
// - Disable, write-only and test clock pins sampled; all high means normal.
// - Voltage decode: 1/0 is 3.3 V, 1/1 is 2.5 V, 0/1 is 1.8 V.
// - Quiesce acknowledge high at release selects standard, low extended precharge.
// - Busy and retry lines are driven high for precharge before release.
// - Standard precharge lasts half a bus cycle.
// - Extended precharge lasts one full bus cycle.
`include "rsmc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rsmc_capture
(
	// Clock and reset
	input  wire logic                        clock_in,
	input  wire logic                        reset_in,
	// Register port
	input  wire logic [`RSMC_ADDR_W-1:0]     reg_addr_in,
	input  wire logic [`RSMC_DATA_W-1:0]     reg_wdata_in,
	input  wire logic                        reg_write_in,
	input  wire logic                        reg_read_in,
	output logic      [`RSMC_DATA_W-1:0]     reg_rdata_out,
	// Reset and strap pins
	input  wire logic                        hard_reset_n_in,
	input  wire logic                        bus_width_strap_in,
	input  wire logic                        data_retry_select_in,
	input  wire logic                        data_bus_disable_pin_n_in,
	input  wire logic                        data_bus_write_only_pin_n_in,
	input  wire logic                        factory_test_clock_pin_in,
	input  wire logic                        io_voltage_select_in,
	input  wire logic                        io_voltage_select_aux_in,
	// Quiesce handshake
	input  wire logic                        quiesce_acknowledge_n_in,
	output logic                             quiesce_request_n_out,
	// Shared bus lines, active low
	input  wire logic                        address_bus_busy_n_in,
	output logic                             address_bus_busy_n_out,
	output logic                             address_bus_busy_oe_out,
	input  wire logic                        data_bus_busy_n_in,
	output logic                             data_bus_busy_n_out,
	output logic                             data_bus_busy_oe_out,
	input  wire logic                        address_retry_n_in,
	output logic                             address_retry_n_out,
	output logic                             address_retry_oe_out,
	// Captured modes
	output logic                             bus_width_64_out,
	output logic                             data_retry_en_out,
	output logic                             factory_mode_out,
	output logic      [1:0]                  io_mode_out,
	output logic                             io_mode_invalid_out,
	output logic                             precharge_extended_out,
	output logic                             straps_valid_out
);

	function automatic rsmc_pkg::rsmc_io_mode_type io_decode(input logic sel, input logic aux);
		rsmc_pkg::rsmc_io_mode_type m;
		case ({sel, aux})
			2'b10:   m = rsmc_pkg::RSMC_IO_3V3;
			2'b11:   m = rsmc_pkg::RSMC_IO_2V5;
			2'b01:   m = rsmc_pkg::RSMC_IO_1V8;
			default: m = rsmc_pkg::RSMC_IO_BAD;
		endcase
		return m;
	endfunction

	function automatic logic [`RSMC_CNT_W-1:0] pre_len(input logic extended);
		pre_len = extended ? `RSMC_CNT_W'(`RSMC_PRE_EXT_CLKS) : `RSMC_CNT_W'(`RSMC_PRE_STD_CLKS);
	endfunction

	// Pin synchronisers
	logic [`RSMC_STRAP_W-1:0] strap_pins;
	logic [`RSMC_STRAP_W-1:0] strap_meta_ff;
	logic [`RSMC_STRAP_W-1:0] strap_sync_ff;
	logic                     hard_reset_in_meta_ff;
	logic                     hard_reset_in_sync_ff;
	logic                     hard_reset_in_prev_ff;
	logic [`RSMC_LINES-1:0]   line_pins;
	logic [`RSMC_LINES-1:0]   line_meta_ff;
	logic [`RSMC_LINES-1:0]   line_sync_ff;
	logic                     release_pulse;

	assign strap_pins = {quiesce_acknowledge_n_in, io_voltage_select_aux_in, io_voltage_select_in,
		factory_test_clock_pin_in, data_bus_write_only_pin_n_in, data_bus_disable_pin_n_in,
		data_retry_select_in, bus_width_strap_in};
	assign line_pins = {address_retry_n_in, data_bus_busy_n_in, address_bus_busy_n_in};

	// Hard reset pin treated as asserted while the chip reset is active
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			strap_meta_ff  <= '0;
			strap_sync_ff  <= '0;
			hard_reset_in_meta_ff <= 1'b0;
			hard_reset_in_sync_ff <= 1'b0;
			hard_reset_in_prev_ff <= 1'b0;
			line_meta_ff   <= '1;
			line_sync_ff   <= '1;
		end
		else
		begin
			strap_meta_ff  <= strap_pins;
			strap_sync_ff  <= strap_meta_ff;
			hard_reset_in_meta_ff <= hard_reset_n_in;
			hard_reset_in_sync_ff <= hard_reset_in_meta_ff;
			hard_reset_in_prev_ff <= hard_reset_in_sync_ff;
			line_meta_ff   <= line_pins;
			line_sync_ff   <= line_meta_ff;
		end
	end

	// Straps share the reset path latency, so both are seen at the same edge
	assign release_pulse = hard_reset_in_sync_ff & ~hard_reset_in_prev_ff;

	// Strap capture
	logic [`RSMC_STRAP_W-1:0]     strap_ff;
	logic [`RSMC_STRAP_W-1:0]     nxt_strap;
	logic                         valid_ff;
	logic                         nxt_valid;
	rsmc_pkg::rsmc_io_mode_type   io_mode_ff;
	rsmc_pkg::rsmc_io_mode_type   nxt_io_mode;

	always_comb
	begin
		nxt_strap   = strap_ff;
		nxt_valid   = valid_ff;
		nxt_io_mode = io_mode_ff;
		if (release_pulse)
		begin
			nxt_strap   = strap_sync_ff;
			nxt_valid   = 1'b1;
			nxt_io_mode = io_decode(strap_sync_ff[`RSMC_S_IOSEL], strap_sync_ff[`RSMC_S_IOAUX]);
		end
	end

	// Values stay put between releases, even through hard reset assertion
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			strap_ff   <= '1;
			valid_ff   <= 1'b0;
			io_mode_ff <= rsmc_pkg::RSMC_IO_BAD;
		end
		else
		begin
			strap_ff   <= nxt_strap;
			valid_ff   <= nxt_valid;
			io_mode_ff <= nxt_io_mode;
		end
	end

	assign bus_width_64_out       = strap_ff[`RSMC_S_BUS_WIDTH];
	assign data_retry_en_out      = strap_ff[`RSMC_S_RETRY];
	assign factory_mode_out       = ~&strap_ff[`RSMC_S_TSTCLK:`RSMC_S_DATA_BUS_DISABLE_PIN];
	assign io_mode_out            = io_mode_ff;
	// Flags a system that broke the select pairing rather than guessing a level
	assign io_mode_invalid_out    = (io_mode_ff == rsmc_pkg::RSMC_IO_BAD);
	assign precharge_extended_out = ~strap_ff[`RSMC_S_QUIESCE_ACKNOWLEDGE];
	assign straps_valid_out       = valid_ff;

	// Control register
	logic [`RSMC_CTRL_W-1:0] ctrl_ff;
	logic [`RSMC_CTRL_W-1:0] nxt_ctrl;

	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (reg_write_in && reg_addr_in == `RSMC_OFF_CTRL)
			nxt_ctrl = reg_wdata_in[`RSMC_CTRL_W-1:0];
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			ctrl_ff <= `RSMC_CTRL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	assign quiesce_request_n_out = ~ctrl_ff[`RSMC_C_QUIESCE_REQUEST];

	// Shared line drivers
	rsmc_pkg::rsmc_line_state_type line_state_ff [`RSMC_LINES];
	rsmc_pkg::rsmc_line_state_type nxt_line_state [`RSMC_LINES];
	logic [`RSMC_CNT_W-1:0]        line_cnt_ff [`RSMC_LINES];
	logic [`RSMC_CNT_W-1:0]        nxt_line_cnt [`RSMC_LINES];
	logic [`RSMC_LINES-1:0]        line_req;
	logic [`RSMC_LINES-1:0]        line_drive;
	logic [`RSMC_LINES-1:0]        line_oe;

	// No drive requests while hard reset holds or before the mode is known; a line already driven still precharges
	assign line_req = ctrl_ff[`RSMC_C_DRIVE_HI:`RSMC_C_DRIVE_LO] & {`RSMC_LINES{valid_ff & hard_reset_in_sync_ff}};

	always_comb
	begin
		for (int i = 0; i < `RSMC_LINES; i++)
		begin
			nxt_line_state[i] = line_state_ff[i];
			nxt_line_cnt[i]   = line_cnt_ff[i];
			case (line_state_ff[i])
				rsmc_pkg::RSMC_LN_IDLE:
				begin
					if (line_req[i])
						nxt_line_state[i] = rsmc_pkg::RSMC_LN_DRIVE;
				end
				rsmc_pkg::RSMC_LN_DRIVE:
				begin
					if (!line_req[i])
					begin
						nxt_line_state[i] = rsmc_pkg::RSMC_LN_PRE;
						nxt_line_cnt[i]   = pre_len(precharge_extended_out);
					end
				end
				rsmc_pkg::RSMC_LN_PRE:
				begin
					nxt_line_cnt[i] = line_cnt_ff[i] - `RSMC_CNT_W'(1);
					if (line_req[i])
						nxt_line_state[i] = rsmc_pkg::RSMC_LN_DRIVE;
					else if (line_cnt_ff[i] == `RSMC_CNT_W'(1))
						nxt_line_state[i] = rsmc_pkg::RSMC_LN_IDLE;
				end
				default:
					nxt_line_state[i] = rsmc_pkg::RSMC_LN_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		for (int i = 0; i < `RSMC_LINES; i++)
		begin
			if (reset_in)
			begin
				line_state_ff[i] <= rsmc_pkg::RSMC_LN_IDLE;
				line_cnt_ff[i]   <= '0;
			end
			else
			begin
				line_state_ff[i] <= nxt_line_state[i];
				line_cnt_ff[i]   <= nxt_line_cnt[i];
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < `RSMC_LINES; i++)
		begin
			line_drive[i] = (line_state_ff[i] == rsmc_pkg::RSMC_LN_DRIVE);
			line_oe[i]    = (line_state_ff[i] != rsmc_pkg::RSMC_LN_IDLE);
		end
	end

	// Driven level is high during precharge, low while driving
	assign address_bus_busy_n_out  = ~line_drive[0];
	assign address_bus_busy_oe_out = line_oe[0];
	assign data_bus_busy_n_out     = ~line_drive[1];
	assign data_bus_busy_oe_out    = line_oe[1];
	assign address_retry_n_out     = ~line_drive[2];
	assign address_retry_oe_out    = line_oe[2];

	// Register reads; unmapped addresses read zero
	logic [`RSMC_DATA_W-1:0] rdata_ff;
	logic [`RSMC_DATA_W-1:0] nxt_rdata;

	always_comb
	begin
		nxt_rdata = '0;
		if (reg_read_in)
		begin
			case (reg_addr_in)
				`RSMC_OFF_STRAP:
				begin
					nxt_rdata[`RSMC_F_STRAP_HI:`RSMC_F_STRAP_LO]     = strap_ff;
					nxt_rdata[`RSMC_F_IO_MODE_HI:`RSMC_F_IO_MODE_LO] = io_mode_ff;
					nxt_rdata[`RSMC_F_IO_INVALID]                   = io_mode_invalid_out;
					nxt_rdata[`RSMC_F_FACTORY]                      = factory_mode_out;
					nxt_rdata[`RSMC_F_EXTENDED]                     = precharge_extended_out;
					nxt_rdata[`RSMC_F_VALID]                        = valid_ff;
				end
				`RSMC_OFF_CTRL:
					nxt_rdata[`RSMC_CTRL_W-1:0] = ctrl_ff;
				`RSMC_OFF_LIVE:
				begin
					nxt_rdata[`RSMC_L_HARD_RESET_IN]                   = ~hard_reset_in_sync_ff;
					nxt_rdata[`RSMC_L_QUIESCE_ACKNOWLEDGE]                     = ~strap_sync_ff[`RSMC_S_QUIESCE_ACKNOWLEDGE];
					nxt_rdata[`RSMC_L_LINES_HI:`RSMC_L_LINES_LO] = ~line_sync_ff;
					nxt_rdata[`RSMC_L_PRE_HI:`RSMC_L_PRE_LO]     = line_oe & ~line_drive;
				end
				default:
					nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			rdata_ff <= '0;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata_out = rdata_ff;

	// Checks
	sequence s_release;
		release_pulse;
	endsequence

	sequence s_leave_drive(int idx);
		line_drive[idx] ##1 !line_drive[idx];
	endsequence

	property p_width;
		@(posedge clock_in) disable iff (reset_in)
		s_release |=> (bus_width_64_out == $past(strap_sync_ff[`RSMC_S_BUS_WIDTH])) && straps_valid_out;
	endproperty
	a_width: assert property (p_width) else $error("bus width not captured at release");

	property p_retry;
		@(posedge clock_in) disable iff (reset_in)
		s_release |=> data_retry_en_out == $past(strap_sync_ff[`RSMC_S_RETRY]);
	endproperty
	a_retry: assert property (p_retry) else $error("retry select not captured");

	property p_factory;
		@(posedge clock_in) disable iff (reset_in)
		(s_release ##0 (&strap_sync_ff[`RSMC_S_TSTCLK:`RSMC_S_DATA_BUS_DISABLE_PIN])) |=> !factory_mode_out;
	endproperty
	a_factory: assert property (p_factory) else $error("factory mode set with all pins high");

	property p_io;
		@(posedge clock_in) disable iff (reset_in)
		(s_release ##0 (strap_sync_ff[`RSMC_S_IOSEL:`RSMC_S_IOSEL] == 1'b1)
			##0 !strap_sync_ff[`RSMC_S_IOAUX]) |=> io_mode_out == 2'h0;
	endproperty
	a_io: assert property (p_io) else $error("select 1 aux 0 not decoded as 3.3 V");

	property p_prech_mode;
		@(posedge clock_in) disable iff (reset_in)
		s_release |=> precharge_extended_out == !$past(strap_sync_ff[`RSMC_S_QUIESCE_ACKNOWLEDGE]);
	endproperty
	a_prech_mode: assert property (p_prech_mode) else $error("precharge mode not captured");

	property p_pre_high;
		@(posedge clock_in) disable iff (reset_in)
		s_leave_drive(0) |-> address_bus_busy_oe_out && address_bus_busy_n_out;
	endproperty
	a_pre_high: assert property (p_pre_high) else $error("busy line not precharged high");

	property p_std_len;
		@(posedge clock_in) disable iff (reset_in)
		(s_leave_drive(1) ##0 !precharge_extended_out) |=> !data_bus_busy_oe_out || !data_bus_busy_n_out;
	endproperty
	a_std_len: assert property (p_std_len) else $error("standard precharge not one clock");

	property p_ext_len;
		@(posedge clock_in) disable iff (reset_in)
		// Second precharge cycle must still drive; a short one drops enable here
		(s_leave_drive(2) ##0 precharge_extended_out) |->
			address_retry_oe_out ##1 address_retry_oe_out;
	endproperty
	a_ext_len: assert property (p_ext_len) else $error("extended precharge too short");

	property p_hold;
		@(posedge clock_in) disable iff (reset_in)
		(valid_ff && !release_pulse) |=> $stable(strap_ff) && $stable(io_mode_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("straps changed without release");

endmodule // rsmc_capture

`default_nettype wire

/* File: rtl/rsmc_map.svh */
/*
 * Offsets, field positions, reset values and timing counts of the strap
 * capture block. Assumes inclusion by bare name from the design files.
 */
`ifndef RSMC_MAP_SVH
`define RSMC_MAP_SVH

// Register bus
`define RSMC_ADDR_W             4
`define RSMC_DATA_W             32
`define RSMC_OFF_STRAP          4'h0
`define RSMC_OFF_CTRL           4'h4
`define RSMC_OFF_LIVE           4'h8

// Strap vector bit positions (pin level as sampled)
`define RSMC_STRAP_W            8
`define RSMC_S_BUS_WIDTH        0
`define RSMC_S_RETRY            1
`define RSMC_S_DATA_BUS_DISABLE_PIN            2
`define RSMC_S_DATA_BUS_WRITE_ONLY_PIN             3
`define RSMC_S_TSTCLK           4
`define RSMC_S_IOSEL            5
`define RSMC_S_IOAUX            6
`define RSMC_S_QUIESCE_ACKNOWLEDGE             7

// Strap status register fields
`define RSMC_F_STRAP_LO         0
`define RSMC_F_STRAP_HI         7
`define RSMC_F_IO_MODE_LO       8
`define RSMC_F_IO_MODE_HI       9
`define RSMC_F_IO_INVALID       10
`define RSMC_F_FACTORY          11
`define RSMC_F_EXTENDED         12
`define RSMC_F_VALID            13

// Control register fields
`define RSMC_CTRL_W             4
`define RSMC_C_DRIVE_LO         0
`define RSMC_C_DRIVE_HI         2
`define RSMC_C_QUIESCE_REQUEST             3
`define RSMC_CTRL_RESET         4'h0

// Live status register fields
`define RSMC_L_HARD_RESET_IN           0
`define RSMC_L_QUIESCE_ACKNOWLEDGE             1
`define RSMC_L_LINES_LO         2
`define RSMC_L_LINES_HI         4
`define RSMC_L_PRE_LO           5
`define RSMC_L_PRE_HI           7

// Shared bus lines: 0 address busy, 1 data busy, 2 address retry
`define RSMC_LINES              3

// Timing: bus cycle is two periods of the 50 MHz clock
`define RSMC_CLK_PERIOD_NS      20
`define RSMC_BUS_CYCLE_NS       40
`define RSMC_CLKS_PER_BUS       (`RSMC_BUS_CYCLE_NS / `RSMC_CLK_PERIOD_NS)
// Precharge in half bus cycles: standard one half, extended one whole
`define RSMC_PRE_STD_HALVES     1
`define RSMC_PRE_EXT_HALVES     2
`define RSMC_PRE_STD_CLKS       ((`RSMC_PRE_STD_HALVES * `RSMC_CLKS_PER_BUS) / 2)
`define RSMC_PRE_EXT_CLKS       ((`RSMC_PRE_EXT_HALVES * `RSMC_CLKS_PER_BUS) / 2)
`define RSMC_CNT_W              2

`endif

/* File: rtl/rsmc_pkg.sv */
/*
 * Types of the strap capture block.
 * Assumes the constants of rsmc_map.svh.
 */
package rsmc_pkg;

	typedef enum logic [1:0]
	{
		RSMC_IO_3V3    = 2'b00,
		RSMC_IO_2V5    = 2'b01,
		RSMC_IO_1V8    = 2'b10,
		RSMC_IO_BAD    = 2'b11
	} rsmc_io_mode_type;

	typedef enum logic [1:0]
	{
		RSMC_LN_IDLE   = 2'b00,
		RSMC_LN_DRIVE  = 2'b01,
		RSMC_LN_PRE    = 2'b10
	} rsmc_line_state_type;

endpackage

/* File: tb/rsmc_sys_model.sv */
/*
 * System side of the strap capture block: hard reset, strap levels,
 * quiesce acknowledge and pull-ups on the shared busy and retry lines.
 * Assumes the bench calls boot() from its own process, one call at a time.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsmc_map.svh"

module rsmc_sys_model
(
	// Clock
	input  wire logic        clock_in,
	// From the design
	input  wire logic        quiesce_request_n_in,
	input  wire logic [2:0]  line_oe_in,
	input  wire logic [2:0]  line_n_in,
	// System pins
	output logic             hard_reset_n_out,
	output logic [7:0]       strap_out,
	output logic             quiesce_acknowledge_n_out,
	output logic [2:0]       line_level_out
);
	logic                    follow_ff;
	logic                    ack_ff;

	// Released lines float up to inactive high
	assign line_level_out = ~line_oe_in | line_n_in;
	// Strap level at release, then answers requests; no inverted-reset tie since both precharge modes are used
	assign quiesce_acknowledge_n_out = follow_ff ? ack_ff : strap_out[`RSMC_S_QUIESCE_ACKNOWLEDGE];
	// No parity pins are modelled, so they stay undriven
	always_ff @(posedge clock_in)
		ack_ff <= quiesce_request_n_in;

	initial
	begin
		hard_reset_n_out = 1'h0;
		strap_out = 8'hBD;
		follow_ff = 1'h0;
	end

	task automatic boot(input logic [7:0] s);
		@(posedge clock_in);
		hard_reset_n_out <= 1'h0;
		follow_ff <= 1'h0;
		strap_out <= s;
		repeat (3) @(posedge clock_in);
		hard_reset_n_out <= 1'h1;
		repeat (2) @(posedge clock_in);
		// Disturb straps to show they are ignored; select kept high so the pair stays legal
		strap_out <= (s ^ 8'hFF) | (8'h01 << `RSMC_S_IOSEL);
		follow_ff <= 1'h1;
		repeat (4) @(posedge clock_in);
	endtask
endmodule // rsmc_sys_model
`default_nettype wire

/* File: tb/test_rsmc_capture.sv */
/*
 * Self-checking bench of the strap capture block.
 * Assumes rsmc_sys_model on the pin side and a plain register port master.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rsmc_map.svh"

module test_rsmc_capture;
	logic                     clock_in;
	logic                     reset_in;
	logic [`RSMC_ADDR_W-1:0]  reg_addr;
	logic [`RSMC_DATA_W-1:0]  reg_wdata;
	logic                     reg_write;
	logic                     reg_read;
	wire  [`RSMC_DATA_W-1:0]  reg_rdata;
	wire                      hard_reset_n;
	wire  [7:0]               strap;
	wire                      quiesce_acknowledge_n;
	wire                      quiesce_request_n;
	wire  [2:0]               line_oe;
	wire  [2:0]               line_n;
	wire  [2:0]               line_lvl;
	wire                      bus_width_64_out;
	wire                      data_retry_en_out;
	wire                      factory_mode_out;
	wire  [1:0]               io_mode_out;
	wire                      io_mode_invalid_out;
	wire                      precharge_extended_out;
	wire                      straps_valid_out;
	int                       n_mismatch;
	int                       samples_checked;
	logic [7:0]               vecs [4] = '{8'hBD, 8'h7A, 8'hD7, 8'hAC};

	rsmc_capture dut
	(
		.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_write_in(reg_write), .reg_read_in(reg_read), .reg_rdata_out(reg_rdata),
		.hard_reset_n_in(hard_reset_n), .bus_width_strap_in(strap[`RSMC_S_BUS_WIDTH]),
		.data_retry_select_in(strap[`RSMC_S_RETRY]), .data_bus_disable_pin_n_in(strap[`RSMC_S_DATA_BUS_DISABLE_PIN]),
		.data_bus_write_only_pin_n_in(strap[`RSMC_S_DATA_BUS_WRITE_ONLY_PIN]), .factory_test_clock_pin_in(strap[`RSMC_S_TSTCLK]),
		.io_voltage_select_in(strap[`RSMC_S_IOSEL]), .io_voltage_select_aux_in(strap[`RSMC_S_IOAUX]),
		.quiesce_acknowledge_n_in(quiesce_acknowledge_n), .quiesce_request_n_out(quiesce_request_n),
		.address_bus_busy_n_in(line_lvl[0]), .address_bus_busy_n_out(line_n[0]),
		.address_bus_busy_oe_out(line_oe[0]), .data_bus_busy_n_in(line_lvl[1]),
		.data_bus_busy_n_out(line_n[1]), .data_bus_busy_oe_out(line_oe[1]),
		.address_retry_n_in(line_lvl[2]), .address_retry_n_out(line_n[2]), .address_retry_oe_out(line_oe[2]),
		.bus_width_64_out(bus_width_64_out), .data_retry_en_out(data_retry_en_out),
		.factory_mode_out(factory_mode_out), .io_mode_out(io_mode_out),
		.io_mode_invalid_out(io_mode_invalid_out), .precharge_extended_out(precharge_extended_out),
		.straps_valid_out(straps_valid_out)
	);

	rsmc_sys_model u_sys
	(
		.clock_in(clock_in), .quiesce_request_n_in(quiesce_request_n), .line_oe_in(line_oe), .line_n_in(line_n),
		.hard_reset_n_out(hard_reset_n), .strap_out(strap), .quiesce_acknowledge_n_out(quiesce_acknowledge_n),
		.line_level_out(line_lvl)
	);

	always #10 clock_in = ~clock_in;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic step();
		@(posedge clock_in);
		#1;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock_in);
		reg_write <= 1'h0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock_in);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge clock_in);
		reg_read <= 1'h0;
		#1;
		d = reg_rdata;
	endtask

	task automatic test_reset();
		logic [31:0] d;
		step();
		check(straps_valid_out, 1'h0, "valid after reset");
		check(factory_mode_out, 1'h0, "factory after reset");
		check(io_mode_out, 2'h3, "io mode after reset");
		check(line_oe, 3'h0, "lines released after reset");
		check(quiesce_request_n, 1'h1, "request idle after reset");
		reg_rd(`RSMC_OFF_CTRL, d);
		check(d, 32'h0000_0000, "control reset value");
		reg_wr(`RSMC_OFF_STRAP, 32'hFFFF_FFFF);
		reg_rd(`RSMC_OFF_STRAP, d);
		check(d[`RSMC_F_VALID], 1'h0, "read-only strap word");
		reg_rd(4'hC, d);
		check(d, 32'h0000_0000, "unmapped read");
	endtask

	task automatic test_precharge(input logic ext);
		logic [31:0] d;
		int          cnt;
		cnt = 0;
		reg_wr(`RSMC_OFF_CTRL, 32'h0000_0007);
		for (int i = 0; i < 6 && line_oe !== 3'h7; i++)
			step();
		check(line_n, 3'h0, "lines driven low");
		// Pin levels need two more edges through the synchroniser
		step();
		reg_rd(`RSMC_OFF_LIVE, d);
		check(d[`RSMC_L_LINES_HI:`RSMC_L_LINES_LO], 3'h7, "lines seen asserted");
		reg_wr(`RSMC_OFF_CTRL, 32'h0000_0000);
		// Each cycle with all lines driven high is precharge
		repeat (8)
		begin
			step();
			if (line_oe === 3'h7 && line_n === 3'h7)
				cnt++;
		end
		check(cnt, ext ? 32'h2 : 32'h1, "precharge length");
		check(line_oe, 3'h0, "lines released after precharge");
		check(line_lvl, 3'h7, "released lines high");
	endtask

	task automatic test_boot(input logic [7:0] s);
		logic [31:0] d;
		logic [1:0]  m;
		logic        f;
		logic        e;
		m = s[`RSMC_S_IOSEL] ? (s[`RSMC_S_IOAUX] ? rsmc_pkg::RSMC_IO_2V5 : rsmc_pkg::RSMC_IO_3V3)
			: rsmc_pkg::RSMC_IO_1V8;
		f = ~(s[`RSMC_S_DATA_BUS_DISABLE_PIN] & s[`RSMC_S_DATA_BUS_WRITE_ONLY_PIN] & s[`RSMC_S_TSTCLK]);
		e = ~s[`RSMC_S_QUIESCE_ACKNOWLEDGE];
		u_sys.boot(s);
		check(bus_width_64_out, s[`RSMC_S_BUS_WIDTH], "bus width");
		check(data_retry_en_out, s[`RSMC_S_RETRY], "data retry");
		check(factory_mode_out, f, "factory mode");
		check(io_mode_out, m, "io mode");
		check(io_mode_invalid_out, 1'h0, "io mode invalid");
		check(precharge_extended_out, e, "extended precharge");
		check(straps_valid_out, 1'h1, "straps valid");
		reg_rd(`RSMC_OFF_STRAP, d);
		check(d, {18'h0, 1'h1, e, f, 1'h0, m, s}, "strap word held");
		test_precharge(e);
	endtask

	task automatic test_quiesce();
		logic [31:0] d;
		reg_wr(`RSMC_OFF_CTRL, 32'h0000_0008);
		step();
		step();
		check(quiesce_request_n, 1'h0, "quiesce request");
		repeat (3) step();
		reg_rd(`RSMC_OFF_LIVE, d);
		check(d[`RSMC_L_QUIESCE_ACKNOWLEDGE], 1'h1, "quiesce acknowledge seen");
		reg_wr(`RSMC_OFF_CTRL, 32'h0000_0000);
		step();
		step();
		check(quiesce_request_n, 1'h1, "quiesce request withdrawn");
	endtask

	task automatic complete_run();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Whole run needs well under 1000 cycles
	initial
	begin
		#(20 * 20000);
		n_mismatch++;
		complete_run();
	end

	initial
	begin
		clock_in = 1'h0;
		reset_in = 1'h1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		reg_write = 1'h0;
		reg_read = 1'h0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (4) @(posedge clock_in);
		reset_in <= 1'h0;
		test_reset();
		foreach (vecs[i])
			test_boot(vecs[i]);
		test_quiesce();
		complete_run();
	end
endmodule // test_rsmc_capture
`default_nettype wire
